// ### hdl/irb_bank.sv
// Register bank of the infrared port: legacy/advanced banking, set selection,
// scratch register, divisor and baud pre-divider.
// Assumes a single synchronous clock mclk_in and an AXI4-Lite master that keeps
// at most one write and one read outstanding.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps

module irb_bank
    import irb_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output irb_status_t      status_out
);

    localparam int FW = $clog2(FIFO_DEPTH + 1);

    // Bus capture registers.
    logic [7:0]  aw_addr_r;
    logic        aw_have_r;
    logic [31:0] w_data_r;
    logic        w_strb0_r;
    logic        w_have_r;

    // Programmer-visible state.
    logic [7:0]  cfg_r;
    logic [2:0]  set_sel_r;
    logic [7:0]  lcr_r;
    logic [7:0]  ien_r;
    logic [7:0]  fctl_r;
    logic [7:0]  hcr_r;
    logic [7:0]  scratch_r;
    logic [15:0] divisor_r;
    logic [7:0]  tx_thr_r;
    logic [7:0]  rx_thr_r;
    logic [15:0] timer_r;
    logic [7:0]  irctl_r;
    logic [7:0]  tx_fifo_r [FIFO_DEPTH];
    logic [FW-1:0] tx_cnt_r;
    logic [7:0]  rx_hold_r;

    // Baud chain.
    logic [15:0] pd_acc_r;
    logic        src_tick_r;
    logic [15:0] div_cnt_r;
    logic        b16_tick_r;
    logic [3:0]  ovs_cnt_r;
    logic        bit_tick_r;

    // Decoded request.
    logic        wr_fire, rd_fire, adv, w_hit, w_cfg, rd_ok;
    logic [2:0]  w_idx;
    logic [7:0]  wbyte, rd_val, isr_adv;
    logic [15:0] pd_sum, pd_lim;

    // Set seen by the window: legacy mode only reaches set 0, or set 1 via the latch bit.
    function automatic logic [2:0] eff_set(input logic a, input logic [2:0] s, input logic [7:0] l);
        eff_set = a ? s : (l[IRB_LCR_DLAB] ? 3'd1 : 3'd0);
    endfunction : eff_set

    // Address decode used for both read and write channels.
    function automatic logic in_window(input logic [7:0] a);
        in_window = (a[7:5] == 3'b000) && (a[1:0] == 2'b00);
    endfunction : in_window

    assign adv     = cfg_r[IRB_CFG_BANK];
    assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid_out;
    assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
    assign w_hit   = in_window(aw_addr_r);
    assign w_cfg   = (aw_addr_r == IRB_ADDR_CFG);
    assign w_idx   = aw_addr_r[4:2];
    assign wbyte   = w_strb0_r ? w_data_r[7:0] : 8'h00;

    // Flag-per-source status: the threshold flag clears only once the store is above the threshold.
    assign isr_adv = {2'b00, (tx_cnt_r <= FW'(tx_thr_r)), 3'b000, (tx_cnt_r == '0), 1'b0};

    // Write address and data are accepted independently, in either order.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            aw_have_r         <= 1'b0;
            w_have_r          <= 1'b0;
            aw_addr_r         <= 8'h00;
            w_data_r          <= 32'h0000_0000;
            w_strb0_r         <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= IRB_RESP_OK;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_addr_r         <= s_axi_awaddr_in;
                aw_have_r         <= 1'b1;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_data_r         <= s_axi_wdata_in;
                w_strb0_r        <= s_axi_wstrb_in[0];
                w_have_r         <= 1'b1;
                s_axi_wready_out <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_r        <= 1'b0;
                w_have_r         <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= (w_hit || w_cfg) ? IRB_RESP_OK : IRB_RESP_SLVERR;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out  <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end

    // Configuration word: bank switch and pre-divider select.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            cfg_r <= IRB_RST_BYTE;
        end else if (wr_fire && w_cfg) begin
            cfg_r <= wbyte;
        end
    end

    // Set selection persists; the register is common to every set at offset 3.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            set_sel_r <= 3'd0;
            lcr_r     <= IRB_RST_BYTE;
        end else if (!adv) begin
            set_sel_r <= 3'd0;  // Leaving advanced mode drops back to set 0.
            if (wr_fire && w_hit && w_idx == IRB_IDX_LCS) begin
                lcr_r <= wbyte;
            end
        end else if (wr_fire && w_hit && w_idx == IRB_IDX_LCS) begin
            set_sel_r <= wbyte[IRB_SSEL_HI:IRB_SSEL_LO];
        end
    end

    // Per-set registers, decoded against the currently visible set.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ien_r     <= IRB_RST_BYTE;
            fctl_r    <= IRB_RST_BYTE;
            hcr_r     <= IRB_RST_BYTE;
            scratch_r <= IRB_RST_BYTE;
            divisor_r <= IRB_RST_DIV;
            tx_thr_r  <= IRB_RST_BYTE;
            rx_thr_r  <= IRB_RST_BYTE;
            irctl_r   <= IRB_RST_BYTE;
        end else if (wr_fire && w_hit) begin
            case (eff_set(adv, set_sel_r, lcr_r))
                3'd0: begin
                    case (w_idx)
                        IRB_IDX_IEN: ien_r     <= adv ? wbyte : {4'h0, wbyte[3:0]};
                        IRB_IDX_IIF: fctl_r    <= {wbyte[7:3], 2'b00, wbyte[0]};
                        IRB_IDX_HCR: hcr_r     <= wbyte;
                        IRB_IDX_SCR: scratch_r <= wbyte;
                        default: ;
                    endcase
                end
                3'd1: begin
                    case (w_idx)
                        IRB_IDX_BUF: divisor_r[7:0]  <= wbyte;
                        IRB_IDX_IEN: divisor_r[15:8] <= wbyte;
                        default: ;
                    endcase
                end
                3'd4: begin
                    case (w_idx)
                        IRB_IDX_BUF: tx_thr_r <= wbyte;
                        IRB_IDX_IEN: rx_thr_r <= wbyte;
                        IRB_IDX_HCR: irctl_r  <= wbyte;
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    end

    // Timer counter in set 4: loaded by software, counts down on bit ticks.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            timer_r <= 16'h0000;
        end else if (wr_fire && w_hit && adv && set_sel_r == 3'd4 && w_idx == IRB_IDX_IIF) begin
            timer_r <= {8'h00, wbyte};
        end else if (irctl_r[0] && bit_tick_r && timer_r != 16'h0000) begin
            timer_r <= timer_r - 16'h0001;
        end
    end

    // Transmit store: 32 entries in advanced mode, one holding register in legacy mode.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            tx_cnt_r <= '0;
        end else if (fctl_r[2]) begin
            tx_cnt_r <= '0;
        end else if (wr_fire && w_hit && eff_set(adv, set_sel_r, lcr_r) == 3'd0 && w_idx == IRB_IDX_BUF) begin
            if (tx_cnt_r < (adv ? FW'(FIFO_DEPTH) : FW'(1))) begin
                tx_fifo_r[tx_cnt_r[FW-2:0]] <= wbyte;
                tx_cnt_r <= tx_cnt_r + FW'(1);
            end
        end else if (bit_tick_r && tx_cnt_r != '0 && ovs_cnt_r == 4'd0) begin
            for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                tx_fifo_r[i] <= tx_fifo_r[i+1];
            end
            tx_cnt_r <= tx_cnt_r - FW'(1);
        end
    end

    // Receive holding byte; the receiver itself is outside this bank.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rx_hold_r <= IRB_RST_BYTE;
        end else if (fctl_r[1]) begin
            rx_hold_r <= IRB_RST_BYTE;
        end
    end

    // Pre-divider: fractional accumulator over the 25 MHz clock models the 24 MHz source.
    always_comb begin
        case (cfg_r[IRB_CFG_PDH:IRB_CFG_PDL])
            IRB_PD_1625: pd_lim = 16'(IRB_PD8_1625) * 16'(IRB_CLK_KHZ / 1000);
            IRB_PD_1:    pd_lim = 16'(IRB_PD8_1) * 16'(IRB_CLK_KHZ / 1000);
            default:     pd_lim = 16'(IRB_PD8_13) * 16'(IRB_CLK_KHZ / 1000);
        endcase
    end
    assign pd_sum = pd_acc_r + 16'(IRB_REF_KHZ / 1000 * 8);

    // Baud-source tick.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pd_acc_r   <= 16'h0000;
            src_tick_r <= 1'b0;
        end else begin
            src_tick_r <= (pd_sum >= pd_lim);
            pd_acc_r   <= (pd_sum >= pd_lim) ? pd_sum - pd_lim : pd_sum;
        end
    end

    // Divisor gives the 16x clock, and every sixteenth tick marks a bit time.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            div_cnt_r  <= 16'h0000;
            b16_tick_r <= 1'b0;
            ovs_cnt_r  <= 4'd0;
            bit_tick_r <= 1'b0;
        end else begin
            b16_tick_r <= 1'b0;
            bit_tick_r <= 1'b0;
            if (src_tick_r) begin
                if (div_cnt_r + 16'h0001 >= divisor_r) begin
                    div_cnt_r  <= 16'h0000;
                    b16_tick_r <= 1'b1;
                    ovs_cnt_r  <= ovs_cnt_r + 4'd1;
                    bit_tick_r <= (ovs_cnt_r == 4'(IRB_OVERSAMP - 1));
                end else begin
                    div_cnt_r <= div_cnt_r + 16'h0001;
                end
            end
        end
    end

    // Read mux, decoded against the visible set.
    always_comb begin
        rd_val = 8'h00;
        rd_ok  = in_window(s_axi_araddr_in) || s_axi_araddr_in == IRB_ADDR_CFG;
        if (s_axi_araddr_in == IRB_ADDR_CFG) begin
            rd_val = cfg_r;
        end else if (s_axi_araddr_in[4:2] == IRB_IDX_LCS) begin
            rd_val = adv ? {5'b0_0000, set_sel_r} : lcr_r;
        end else begin
            case (eff_set(adv, set_sel_r, lcr_r))
                3'd0: begin
                    case (s_axi_araddr_in[4:2])
                        IRB_IDX_BUF: rd_val = rx_hold_r;
                        IRB_IDX_IEN: rd_val = ien_r;
                        IRB_IDX_IIF: rd_val = adv ? isr_adv : {fctl_r[0], fctl_r[0], 6'h01};
                        IRB_IDX_HCR: rd_val = hcr_r;
                        IRB_IDX_LST: rd_val = (tx_cnt_r == '0) ? IRB_LSR_IDLE : 8'h00;
                        IRB_IDX_SCR: rd_val = scratch_r;
                        default:     rd_val = 8'h00;
                    endcase
                end
                3'd1: begin
                    case (s_axi_araddr_in[4:2])
                        IRB_IDX_BUF: rd_val = divisor_r[7:0];
                        IRB_IDX_IEN: rd_val = divisor_r[15:8];
                        default:     rd_val = 8'h00;
                    endcase
                end
                3'd4: begin
                    case (s_axi_araddr_in[4:2])
                        IRB_IDX_BUF: rd_val = tx_thr_r;
                        IRB_IDX_IEN: rd_val = rx_thr_r;
                        IRB_IDX_IIF: rd_val = timer_r[7:0];
                        IRB_IDX_HCR: rd_val = irctl_r;
                        default:     rd_val = 8'h00;
                    endcase
                end
                default: rd_val = 8'h00;
            endcase
        end
    end

    // Read channel: address taken when idle, data one cycle later.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= IRB_RESP_OK;
        end else if (rd_fire) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_ok ? {24'h00_0000, rd_val} : 32'h0000_0000;
            s_axi_rresp_out   <= rd_ok ? IRB_RESP_OK : IRB_RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

    // Status outputs registered straight from state.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            status_out <= '0;
        end else begin
            status_out <= '{advanced: adv, set_sel: eff_set(adv, set_sel_r, lcr_r),
                            baud16_tick: b16_tick_r, bit_tick: bit_tick_r};
        end
    end

endmodule : irb_bank

// ### hdl/irb_pkg.sv
// Package for the infrared port register bank: offsets, fields, reset values
// and baud pre-divider constants.
// Assumes a single 25 MHz clock domain and an AXI4-Lite register bus.
package irb_pkg;

    // Register word indices within a set; byte address is four times the index.
    localparam logic [2:0] IRB_IDX_BUF   = 3'h0;
    localparam logic [2:0] IRB_IDX_IEN   = 3'h1;
    localparam logic [2:0] IRB_IDX_IIF   = 3'h2;
    localparam logic [2:0] IRB_IDX_LCS   = 3'h3;
    localparam logic [2:0] IRB_IDX_HCR   = 3'h4;
    localparam logic [2:0] IRB_IDX_LST   = 3'h5;
    localparam logic [2:0] IRB_IDX_HST   = 3'h6;
    localparam logic [2:0] IRB_IDX_SCR   = 3'h7;

    // Device configuration word, outside the eight-location window.
    localparam logic [7:0] IRB_ADDR_CFG  = 8'h20;
    localparam int         IRB_CFG_BANK  = 0;     // bank_switch_enable bit.
    localparam int         IRB_CFG_PDL   = 1;     // Pre-divider select, low bit.
    localparam int         IRB_CFG_PDH   = 2;     // Pre-divider select, high bit.

    // Set-select field in the line_ctrl_set_select register (advanced mode).
    localparam int         IRB_SSEL_LO   = 0;
    localparam int         IRB_SSEL_HI   = 2;
    // Line control bit 7 opens the divisor set in legacy mode.
    localparam int         IRB_LCR_DLAB  = 7;

    // Reset values.
    localparam logic [7:0]  IRB_RST_BYTE = 8'h00;
    localparam logic [15:0] IRB_RST_DIV  = 16'h000c;
    localparam logic [7:0]  IRB_ISR_IDLE = 8'h01;   // Legacy: no interrupt pending.
    localparam logic [7:0]  IRB_ISR_ADV  = 8'h22;   // Advanced reset value of status.
    localparam logic [7:0]  IRB_LSR_IDLE = 8'h60;   // Transmitter empty flags.

    // Pre-divider choices: 24 MHz divided by 13, 1.625 or 1.0.
    // Expressed as a rational ratio of 24 MHz ticks per baud-source tick, times 8.
    localparam logic [1:0] IRB_PD_13    = 2'h0;
    localparam logic [1:0] IRB_PD_1625  = 2'h1;
    localparam logic [1:0] IRB_PD_1     = 2'h2;
    localparam logic [7:0] IRB_PD8_13   = 8'd104;    // 13 * 8.
    localparam logic [7:0] IRB_PD8_1625 = 8'd13;     // 1.625 * 8.
    localparam logic [7:0] IRB_PD8_1    = 8'd8;      // 1.0 * 8.

    // Reference frequencies in kHz; the reference is scaled onto the 25 MHz clock.
    localparam int         IRB_REF_KHZ  = 24000;
    localparam int         IRB_CLK_KHZ  = 25000;
    localparam int         IRB_OVERSAMP = 16;

    // AXI responses.
    localparam logic [1:0] IRB_RESP_OK     = 2'h0;
    localparam logic [1:0] IRB_RESP_SLVERR = 2'h2;

    // Bank outputs carried together.
    typedef struct packed {
        logic       advanced;
        logic [2:0] set_sel;
        logic       baud16_tick;
        logic       bit_tick;
    } irb_status_t;

endpackage : irb_pkg

// ### tb/irb_bank_sva.sv
// Checker for the infrared port register bank: bus handshakes and banking.
// Assumes it is bound to irb_bank and sees only that module's ports.
`timescale 1ns/10ps

module irb_bank_sva
    import irb_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        srst_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0]  s_axi_rresp_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire irb_status_t status_out
);
    // One clock domain.
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    // Bus handshakes and the answers that follow them.
    chk_reset_idle_state: assert property ($fell(srst_in) |-> s_axi_awready_out && s_axi_arready_out
        && !s_axi_bvalid_out && !s_axi_rvalid_out && !status_out.advanced && status_out.set_sel == 3'h0)
        else $error("bank not idle after reset");
    chk_write_answer_due: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |-> ##[1:3] s_axi_bvalid_out) else $error("write answer missing");
    chk_read_answer_due: assert property (s_axi_arvalid_in && s_axi_arready_out |-> ##[1:2] s_axi_rvalid_out)
        else $error("read answer missing");
    chk_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
        && $stable(s_axi_bresp_out)) else $error("write answer dropped early");
    chk_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
        && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out)) else $error("read answer dropped early");
    chk_write_busy_ready: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write accepted while busy");
    chk_read_busy_ready: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read accepted while busy");
    chk_rdata_one_byte: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0000_00)
        else $error("upper read bytes not zero");
    chk_slverr_zero_data: assert property (s_axi_rvalid_out && s_axi_rresp_out == IRB_RESP_SLVERR
        |-> s_axi_rdata_out == 32'h0000_0000) else $error("refused read carries data");

    // Banking changes only through a completed register write.
    chk_legacy_two_sets: assert property (!status_out.advanced |-> status_out.set_sel <= 3'h1)
        else $error("advanced set visible in legacy mode");
    chk_set_persists: assert property (!$stable(status_out.set_sel) |-> s_axi_bvalid_out
        || $past(s_axi_bvalid_out)) else $error("set changed without a write");
    chk_mode_persists: assert property (!$stable(status_out.advanced) |-> s_axi_bvalid_out
        || $past(s_axi_bvalid_out)) else $error("mode changed without a write");
endmodule : irb_bank_sva

bind irb_bank irb_bank_sva u_irb_bank_sva (.mclk_in(mclk_in), .srst_in(srst_in),
    .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in), .status_out(status_out));

// ### tb/irb_bank_tb.sv
// Self-checking bench for the infrared port register bank.
// Assumes the checker is bound in separately; the bench acts as AXI4-Lite master.
`timescale 1ns/10ps

module irb_bank_tb
    import irb_pkg::*;
;
    logic        mclk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [7:0]  s_axi_awaddr_in = 8'h00;
    logic        s_axi_awvalid_in = 1'b0;
    logic [31:0] s_axi_wdata_in = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb_in = 4'h1;
    logic        s_axi_wvalid_in = 1'b0;
    logic        s_axi_bready_in = 1'b0;
    logic [7:0]  s_axi_araddr_in = 8'h00;
    logic        s_axi_arvalid_in = 1'b0;
    logic        s_axi_rready_in = 1'b0;
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r;
    logic [31:0] s_axi_rdata_out, d;
    irb_status_t status_out;
    logic [31:0] seed = 32'h9cc4_ce76;
    logic [7:0]  v, t, ien;
    logic [1:0]  pdc [3] = '{IRB_PD_13, IRB_PD_1625, IRB_PD_1};
    logic [7:0]  pd8 [3] = '{IRB_PD8_13, IRB_PD8_1625, IRB_PD8_1};
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          n16, nbit, e;
    logic        cnt_on = 1'b0;

    // Free-running 25 MHz clock.
    always #20 mclk_in = ~mclk_in;

    irb_bank dut (.mclk_in(mclk_in), .srst_in(srst_in),
        .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
        .s_axi_wdata_in(s_axi_wdata_in), .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
        .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
        .s_axi_bready_in(s_axi_bready_in), .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
        .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
        .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in), .status_out(status_out));

    // Tick counters, gated by the main sequence.
    always @(posedge mclk_in) begin
        if (cnt_on) begin
            n16  += int'(status_out.baud16_tick === 1'b1);
            nbit += int'(status_out.bit_tick === 1'b1);
        end
    end

    function automatic logic [31:0] xs_next(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs_next

    // Legacy operation keeps only the low nibble of the interrupt enables.
    function automatic logic [31:0] exp_ien(input logic [7:0] w, input logic adv);
        return adv ? {24'h0, w} : {28'h0, w[3:0]};
    endfunction : exp_ien

    // Ticks expected in cyc clocks: 24 MHz times 8 over pre-divider times 8 and divisor.
    function automatic int exp_ticks(input int p8, input int dv, input int cyc);
        return cyc * IRB_REF_KHZ * 8 / (IRB_CLK_KHZ * p8 * dv);
    endfunction : exp_ticks

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Accumulator phase jitters counts by a tick or two.
    task automatic chk_near(input int got, input int exp, input string what);
        cmp_count++;
        if (got < exp - 2 || got > exp + 2) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s count %0d expected %0d", $time, what, got, exp);
        end
    endtask : chk_near

    // Write: address and data offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] w, output logic [1:0] rs);
        @(posedge mclk_in);
        s_axi_awaddr_in  <= a;
        s_axi_wdata_in   <= {seed[31:8], w};
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in  <= 1'b1;
        s_axi_bready_in  <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1);
        rs = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rs);
        @(posedge mclk_in);
        s_axi_araddr_in  <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in  <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1);
        q = s_axi_rdata_out;
        rs = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
    endtask : rd

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // Watchdog: about nine times the sequence length.
    initial begin
        repeat (30000) @(posedge mclk_in);
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        summarize();
    end

    // Main sequence: reset values, refusal, scratch, divisor, baud rates, banking.
    initial begin
        repeat (16) @(posedge mclk_in);
        srst_in <= 1'b0;
        rd(8'h1C, d, r); chk(d, {24'h0, IRB_RST_BYTE}, "scratch reset");
        rd(8'h08, d, r); chk(d, {24'h0, IRB_ISR_IDLE}, "legacy ident");
        rd(8'h14, d, r); chk(d, {24'h0, IRB_LSR_IDLE}, "line status reset");
        wr(8'h24, 8'h5a, r); chk({30'h0, r}, {30'h0, IRB_RESP_SLVERR}, "unmapped write");
        rd(8'h24, d, r); chk({30'h0, r}, {30'h0, IRB_RESP_SLVERR}, "unmapped read");
        for (int i = 0; i < 6; i++) begin
            seed = xs_next(seed);
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
            ien = ~seed[15:8];
            wr(8'h04, ien, r);
            wr(8'h1C, v, r);
            rd(8'h1C, d, r); chk(d, {24'h0, v}, "scratch readback");
            rd(8'h04, d, r); chk(d, exp_ien(ien, 1'b0), "enables untouched");
        end
        wr(8'h0C, 8'h80, r);
        rd(8'h00, d, r); chk(d, {24'h0, IRB_RST_DIV[7:0]}, "divisor low reset");
        rd(8'h04, d, r); chk(d, {24'h0, IRB_RST_DIV[15:8]}, "divisor high reset");
        wr(8'h00, 8'h02, r);
        wr(8'h04, 8'h00, r);
        rd(8'h00, d, r); chk(d, 32'h0000_0002, "divisor low");
        wr(8'h0C, 8'h00, r);
        rd(8'h04, d, r); chk(d, exp_ien(ien, 1'b0), "set 0 back");
        for (int p = 0; p < 3; p++) begin
            wr(IRB_ADDR_CFG, {5'h0, pdc[p], 1'b0}, r);
            repeat (8) @(posedge mclk_in);
            n16 = 0;
            nbit = 0;
            cnt_on = 1'b1;
            repeat (1000) @(posedge mclk_in);
            cnt_on = 1'b0;
            e = exp_ticks(pd8[p], 2, 1000);
            chk_near(n16, e, "baud16 rate");
            chk_near(nbit, e / IRB_OVERSAMP, "bit rate");
        end
        wr(IRB_ADDR_CFG, 8'h01, r);
        @(negedge mclk_in);
        chk({31'h0, status_out.advanced}, 32'h0000_0001, "advanced on");
        rd(8'h08, d, r); chk(d, {24'h0, IRB_ISR_ADV}, "advanced ident");
        wr(8'h04, 8'hf0, r);
        rd(8'h04, d, r); chk(d, exp_ien(8'hf0, 1'b1), "advanced enables");
        for (int s = 7; s >= 0; s--) begin
            seed = xs_next(seed);
            wr(8'h0C, {seed[7:3], 3'(s)}, r);
            rd(8'h0C, d, r); chk(d, 32'(s), "set select readback");
            chk({29'h0, status_out.set_sel}, 32'(s), "visible set");
        end
        seed = xs_next(seed);
        t = seed[7:0];
        wr(8'h0C, 8'h04, r);
        wr(8'h00, t, r);
        wr(8'h0C, 8'h00, r);
        wr(8'h1C, ~t, r);
        wr(8'h0C, 8'h04, r);
        rd(8'h00, d, r); chk(d, {24'h0, t}, "set 4 threshold kept");
        rd(8'h0C, d, r); chk(d, 32'h0000_0004, "set 4 selector");
        wr(8'h0C, 8'h00, r);
        rd(8'h1C, d, r); chk(d, {24'h0, ~t}, "advanced scratch");
        wr(8'h0C, 8'h05, r);
        wr(IRB_ADDR_CFG, 8'h00, r);
        @(negedge mclk_in);
        chk({31'h0, status_out.advanced}, 32'h0000_0000, "advanced off");
        chk({29'h0, status_out.set_sel}, 32'h0000_0000, "set forced to 0");
        summarize();
    end
endmodule : irb_bank_tb
